// >>> src/bus_busy_pkg.sv
// Package with constants shared by the bus-busy tracker and its helper.
package bus_busy_pkg;

   // Value of the bus-busy flag after power-up and after device reset.
   localparam logic BUSY_RESET_VAL = 1'b0;

   // Depth of the input synchroniser chain on the two bus wires.
   localparam int   SYNC_STAGES    = 2;

   // Bus period in the bench, in nanoseconds, and module clock period.
   localparam int   LINK_PERIOD_NS = 400;
   localparam int   CLK_PERIOD_NS  = 50;

   // Module clock cycles per bus period; the bench writes its 8-cycle waits as literals.
   localparam int   LINK_CYCLES    = LINK_PERIOD_NS / CLK_PERIOD_NS;

endpackage : bus_busy_pkg

// >>> src/pin_sync.sv
// Two-stage synchroniser for one asynchronous input pin.
module pin_sync (
   input  wire logic clk,     // Module clock.
   input  wire logic rst_b,   // Synchronous reset, active low.
   input  wire logic rst_val, // Level taken while in reset.
   input  wire logic pin,     // Asynchronous pin level.
   output logic      pin_s    // Synchronised level.
);

   logic meta_r;             // First stage, read only by the second.

   ////////////////////////////////////////////////////////////////////////
   // The first stage feeds only the second stage, so that a metastable
   // value never reaches any logic. Both stages reset to the pin's idle
   // level, so no false edge is seen when reset is released.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         meta_r <= rst_val;
         pin_s  <= rst_val;
      end else begin
         meta_r <= pin;
         pin_s  <= meta_r;
      end
   end

endmodule // pin_sync

// >>> src/bus_busy_tracker.sv
// Bus-busy tracker: watches START and STOP on the two-wire bus.
module bus_busy_tracker
(
   input  wire logic clk,                  // Module clock, 20 MHz.
   input  wire logic rst_b,                // Device reset, active low.
   input  wire logic module_reset_release, // 1 lets the module run.
   input  wire logic scl_i,                // Bus clock wire level.
   input  wire logic sda_i,                // Bus data wire level.
   output logic      bus_occupied_flag,    // 1 while the bus is busy.
   output logic      flag_valid,           // 1 once a condition was seen.
   output logic      start_seen,           // One-cycle START pulse.
   output logic      stop_seen             // One-cycle STOP pulse.
);
   import bus_busy_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Synchronisers: both wires come from outside the clock domain.

   logic scl_s;              // Synchronised clock wire.
   logic sda_s;              // Synchronised data wire.

   pin_sync u_scl_sync (
      .clk     (clk),
      .rst_b   (rst_b),
      .rst_val (1'b1),
      .pin     (scl_i),
      .pin_s   (scl_s)
   );

   pin_sync u_sda_sync (
      .clk     (clk),
      .rst_b   (rst_b),
      .rst_val (1'b1),
      .pin     (sda_i),
      .pin_s   (sda_s)
   );

   ////////////////////////////////////////////////////////////////////////
   // Control enable, also synchronised because software drives it from
   // another part of the chip that may not share this clock.

   logic run_m_r;            // First stage of the enable synchroniser.
   logic run_r;              // Synchronised module enable.

   // Enable synchroniser; run_m_r is read by run_r only.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         run_m_r <= 1'b0;
         run_r   <= 1'b0;
      end else begin
         run_m_r <= module_reset_release;
         run_r   <= run_m_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Previous wire levels for edge finding.

   logic scl_d_r;            // Clock wire one cycle ago.
   logic sda_d_r;            // Data wire one cycle ago.

   // Delayed copies of the synchronised wires.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   // START is data falling while the clock is high, STOP data rising.
   // In module reset neither is recognised at all.
   logic start_det;          // Raw START this cycle.
   logic stop_det;           // Raw STOP this cycle.

   assign start_det = run_r && scl_s && scl_d_r && sda_d_r && !sda_s;
   assign stop_det  = run_r && scl_s && scl_d_r && !sda_d_r && sda_s;

   ////////////////////////////////////////////////////////////////////////
   // Busy flag. Apart from device reset it is only written by detected conditions, so module reset
   // leaves it frozen; a trade-off is that it may be stale until the next
   // condition, which software must allow for.

   logic busy_r;             // Bus-busy state.

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         busy_r <= BUSY_RESET_VAL;
      end else if (start_det) begin
         busy_r <= 1'b1;
      end else if (stop_det) begin
         busy_r <= 1'b0;
      end
      // Otherwise hold, including during module reset.
   end

   ////////////////////////////////////////////////////////////////////////
   // Validity: set by the first condition after release, cleared whenever
   // the module is in reset, so software can tell a stale flag.

   logic valid_r;            // Flag has tracked a real condition.

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         valid_r <= 1'b0;
      end else if (!run_r) begin
         valid_r <= 1'b0;
      end else if (start_det || stop_det) begin
         valid_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered condition pulses for observation.

   logic start_r;            // START pulse.
   logic stop_r;             // STOP pulse.

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         start_r <= 1'b0;
         stop_r  <= 1'b0;
      end else begin
         start_r <= start_det;
         stop_r  <= stop_det;
      end
   end

   assign bus_occupied_flag = busy_r;
   assign flag_valid        = valid_r;
   assign start_seen        = start_r;
   assign stop_seen         = stop_r;

   ////////////////////////////////////////////////////////////////////////
   // Assertions. All are clocked by the module clock and switched off by
   // device reset, except the power-up check, which must hold while
   // reset is applied. START and STOP never fall in one cycle, since the
   // data wire cannot both fall and rise in one sample.

   sequence s_start_ev;
      run_r && scl_s && scl_d_r && sda_d_r && !sda_s;
   endsequence

   sequence s_stop_ev;
      run_r && scl_s && scl_d_r && !sda_d_r && sda_s;
   endsequence

   AST_START_SETS:
      assert property (@(posedge clk) disable iff (!rst_b)
         s_start_ev |=> bus_occupied_flag && start_seen)
      else $error("START did not set busy flag");

   AST_STOP_CLEARS:
      assert property (@(posedge clk) disable iff (!rst_b)
         s_stop_ev |=> !bus_occupied_flag && stop_seen)
      else $error("STOP did not clear busy flag");

   AST_NO_DET_IN_RST:
      assert property (@(posedge clk) disable iff (!rst_b)
         !run_r |=> !start_seen && !stop_seen)
      else $error("Condition seen during module reset");

   AST_FROZEN:
      assert property (@(posedge clk) disable iff (!rst_b)
         !run_r |=> $stable(bus_occupied_flag))
      else $error("Busy flag moved during module reset");

   AST_HOLD_UNTIL_EV:
      assert property (@(posedge clk) disable iff (!rst_b)
         $changed(bus_occupied_flag) |-> $past(start_det) || $past(stop_det))
      else $error("Busy flag changed without a condition");

   AST_POWERUP_ZERO:
      assert property (@(posedge clk)
         !rst_b |=> !bus_occupied_flag)
      else $error("Busy flag not zero after reset");

   AST_VALID_CLR:
      assert property (@(posedge clk) disable iff (!rst_b)
         !run_r |=> !flag_valid)
      else $error("Flag valid during module reset");

   AST_VALID_SET:
      assert property (@(posedge clk) disable iff (!rst_b)
         (s_start_ev or s_stop_ev) |=> flag_valid)
      else $error("Flag valid not set by condition");

   ////////////////////////////////////////////////////////////////////////
   // Helper for the assertions only: remembers whether the module has run
   // since device reset, so that the power-up value can be checked for as
   // long as it must stand, whatever the bus does meanwhile.

   logic ever_run_r;         // Set by the first synchronised release.

   // Set once and held until the next device reset.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ever_run_r <= 1'b0;
      end else if (run_r) begin
         ever_run_r <= 1'b1;
      end
   end

   // Until the first release, bus traffic must not move the flag off 0.
   AST_ZERO_BEFORE_RUN:
      assert property (@(posedge clk) disable iff (!rst_b)
         !ever_run_r |-> !bus_occupied_flag)
      else $error("Busy flag left zero before first release");

   // A START pulse stands for exactly one cycle.
   AST_START_PULSE:
      assert property (@(posedge clk) disable iff (!rst_b)
         start_seen |=> !start_seen)
      else $error("START pulse longer than one cycle");

   // Validity only rises on a condition seen while running.
   AST_VALID_RISE:
      assert property (@(posedge clk) disable iff (!rst_b)
         $rose(flag_valid) |-> $past(start_det) || $past(stop_det))
      else $error("Flag valid rose without a condition");

endmodule // bus_busy_tracker

// >>> testbench/bus_master_model.sv
// Behavioural far-side master that makes START, data bits and STOP.
module bus_master_model (
   output logic scl, // Bus clock wire, idle high.
   output logic sda  // Bus data wire, idle high.
);
   timeunit 1ns;
   timeprecision 1ps;
   //////////////////////////////////////////////////////////////////////
   // Both wires idle high; the clock stands still outside frames.
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // Every task starts and ends on a module clock edge, while its wire
   // edges sit 10 ns after one, so they never race the sampling flops.
   // Edges sit at least 100 ns apart so the block never sees them in one sample.
   // Data falls while the clock is high, then the clock drops.
   task automatic start_cond;
      #110 sda = 1'b0;
      #100 scl = 1'b0;
      #90;
   endtask
   // One data bit, moved while the clock is low; 400 ns clock period.
   task automatic send_bit(input logic b);
      #10 sda = b;
      #100 scl = 1'b1;
      #200 scl = 1'b0;
      #90;
   endtask
   // Data rises while the clock is high; the bus is then idle.
   task automatic stop_cond;
      #10 sda = 1'b0;
      #100 scl = 1'b1;
      #100 sda = 1'b1;
      #90;
   endtask
endmodule // bus_master_model

// >>> testbench/tb.sv
// Self-checking bench for the bus-busy tracker.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk   = 1'b0;  // Module clock.
   logic rst_b = 1'b0;  // Device reset, active low.
   logic rel   = 1'b0;  // Module reset release.
   logic scl, sda;      // Bus wires from the far-side master.
   logic flag, valid;   // Busy flag and its validity.
   logic st, sp;        // Condition pulses.
   logic got_st = 1'b0; // A START pulse was caught.
   logic got_sp = 1'b0; // A STOP pulse was caught.
   logic clr_got = 1'b0; // Clears both pulse latches.
   // Software's wait after release, longer than the longest transfer.
   localparam int SETTLE_CYC = 100;
   int   errors = 0;    // Mismatches.
   int   n_tests = 0;   // Comparisons made.
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin errors++; \
   $display("wrong value at %0t: got %b want %b", $time, a, e); end end
   //////////////////////////////////////////////////////////////////////
   always #25 clk = ~clk;
   // Pulses last one cycle, so they are latched for later checks.
   // One process owns both latches, so a clear never races a pulse.
   always @(posedge clk) begin
      if (clr_got) begin
         got_st <= 1'b0;
         got_sp <= 1'b0;
      end else begin
         if (st === 1'b1) got_st <= 1'b1;
         if (sp === 1'b1) got_sp <= 1'b1;
      end
   end
   bus_master_model bus (.scl(scl), .sda(sda));
   bus_busy_tracker DUT (.clk(clk), .rst_b(rst_b),
      .module_reset_release(rel), .scl_i(scl), .sda_i(sda),
      .bus_occupied_flag(flag), .flag_valid(valid),
      .start_seen(st), .stop_seen(sp));
   //////////////////////////////////////////////////////////////////////
   // Lets the flag settle after a condition; latency is three edges.
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic clear_got;
      clr_got <= 1'b1;
      @(posedge clk);
      clr_got <= 1'b0;
   endtask
   // Software polls the flag for a free bus before any transfer.
   task automatic poll_free;
      int k;
      k = 0;
      while (flag !== 1'b0 && k < 200) begin
         @(posedge clk);
         k++;
      end
      `CHK(flag, 1'b0)
   endtask
   // Before release, bus traffic must leave the flag at zero.
   task automatic t_powerup;
      `CHK(flag, 1'b0)
      bus.start_cond();
      settle(8);
      `CHK(flag, 1'b0)
      `CHK(got_st, 1'b0)
      bus.stop_cond();
      settle(8);
      `CHK(flag, 1'b0)
      `CHK(got_sp, 1'b0)
      `CHK(valid, 1'b0)
   endtask
   // After release, START sets and STOP clears the flag.
   task automatic t_run;
      @(posedge clk);
      rel <= 1'b1;
      settle(SETTLE_CYC);
      poll_free();
      `CHK(valid, 1'b0)
      clear_got();
      bus.start_cond();
      settle(8);
      `CHK(flag, 1'b1)
      `CHK(got_st, 1'b1)
      `CHK(valid, 1'b1)
      bus.stop_cond();
      settle(8);
      `CHK(flag, 1'b0)
      `CHK(got_sp, 1'b1)
   endtask
   // Module reset freezes a busy flag; first STOP after release clears.
   task automatic t_freeze;
      clear_got();
      bus.start_cond();
      settle(8);
      `CHK(flag, 1'b1)
      rel <= 1'b0;
      settle(8);
      `CHK(valid, 1'b0)
      clear_got();
      bus.stop_cond();
      settle(8);
      `CHK(flag, 1'b1)
      `CHK(got_sp, 1'b0)
      rel <= 1'b1;
      settle(8);
      `CHK(flag, 1'b1)
      `CHK(valid, 1'b0)
      // Another master's transfer lands inside the settling wait.
      bus.start_cond();
      settle(8);
      `CHK(flag, 1'b1)
      `CHK(valid, 1'b1)
      bus.stop_cond();
      settle(SETTLE_CYC);
      `CHK(flag, 1'b0)
      `CHK(valid, 1'b1)
      poll_free();
   endtask
   // A whole byte and its acknowledge keep the flag set; only STOP clears.
   task automatic t_byte;
      logic [7:0] data_v;
      data_v = 8'ha5;
      clear_got();
      bus.start_cond();
      for (int i = 7; i >= 0; i--) begin
         bus.send_bit(data_v[i]);
      end
      bus.send_bit(1'b0);
      `CHK(flag, 1'b1)
      `CHK(got_st, 1'b1)
      `CHK(got_sp, 1'b0)
      bus.stop_cond();
      settle(8);
      `CHK(flag, 1'b0)
      `CHK(got_sp, 1'b1)
   endtask
   //////////////////////////////////////////////////////////////////////
   task automatic close_out;
      if (errors == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Main sequence: reset for 12 cycles, then the scenarios in order.
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      settle(2);
      t_powerup();
      t_run();
      t_freeze();
      t_byte();
      close_out();
   end
   // The tests take well under 40 us; a hang is cut off at 200 us.
   initial begin
      #200000;
      errors++;
      close_out();
   end
endmodule // tb
